// ---- tvf_pkg.sv ----
// Shared constants for the fault-response block: command codes, field layout, timing.
// Assumes a single 40 MHz system clock shared by both ends.
package tvf_pkg;
    localparam int ClkHz = 40_000_000;
    localparam int RetryUnitMs = 200;
    localparam longint RetryUnitCyclesL = longint'(ClkHz) / 1000 * RetryUnitMs;
    localparam int RetryUnitCycles = int'(RetryUnitCyclesL);
    localparam logic [7:0] CmdOtFaultLimit = 8'h4f;
    localparam logic [7:0] CmdOtFaultReaction = 8'h50;
    localparam logic [7:0] CmdOtWarnThreshold = 8'h51;
    localparam logic [7:0] CmdVinOvThreshold = 8'h55;
    localparam logic [7:0] CmdVinOvReaction = 8'h56;
    localparam int DelayLsb = 0;
    localparam int DelayMsb = 2;
    localparam int RetryLsb = 3;
    localparam int RetryMsb = 5;
    localparam int RespLsb = 6;
    localparam int RespMsb = 7;
    localparam logic [1:0] RespIgnore = 2'h0;
    localparam logic [1:0] RespDisable = 2'h2;
    localparam logic [2:0] RetryNone = 3'h0;
    localparam logic [2:0] RetryForever = 3'h7;
    localparam logic [7:0] ReactionReset = 8'h80;
    localparam logic [15:0] OtFaultLimitReset = 16'h007d;
    localparam logic [15:0] OtWarnReset = 16'h0078;
    localparam logic [15:0] VinOvReset = 16'h0000;
    localparam logic [2:0] CtlAddrCmd = 3'h0;
    localparam logic [2:0] CtlAddrDataLo = 3'h1;
    localparam logic [2:0] CtlAddrDataHi = 3'h2;
    localparam logic [2:0] CtlAddrStatus = 3'h3;
    typedef enum logic [1:0] {
        TvfRun = 2'b00,
        TvfWait = 2'b01,
        TvfLatched = 2'b10
    } tvf_state_t;
endpackage

// ---- tvf_link_if.sv ----
// Interface joining the host controller and the fault-response device.
// Command writes are one-cycle strobes of code and 16-bit data.
`timescale 1ns/1ps
interface tvf_link_if;
    logic cmdWrite;
    logic [7:0] cmdCode;
    logic [15:0] cmdData;
    logic [7:0] faultStatus;
    modport device (input cmdWrite, input cmdCode, input cmdData, output faultStatus);
    modport host (output cmdWrite, output cmdCode, output cmdData, input faultStatus);
endinterface

// ---- tvf_fault_device.sv ----
// Fault-response device: holds settings, applies shutdown/retry policy per fault.
// Assumes temperature and input voltage arrive already converted, synchronous to clk_sys.
// How it works
// - Bits 2:0 give restart wait, 200 ms steps
// - Response 00: keep running, ignore fault
// - Response 10: disable output, then apply retries
// - Retry count 000: stay off until cleared
// - Retries 1 to 6, then latch off
// - Attempt-to-attempt spacing equals delay times unit; delay 0 gives one unit
// - Retry 111 repeats until off, bias, fault
// - Over-temperature reaction lives at command 0x50
// - Input over-voltage reaction lives at command 0x56
// - Host writes warning limit, exponent zero, Celsius
// - Host writes over-voltage limit, exponent minus three
// - Fault status bit set for every response
// - Host writes fault limit, exponent zero, Celsius
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module tvf_fault_device
    import tvf_pkg::*;
#(
    parameter int RetryUnit = RetryUnitCycles
) (
    input wire logic clk_sys,
    input wire logic reset,
    tvf_link_if.device link,
    input wire logic [15:0] tempC,
    input wire logic [15:0] vinMilli8,
    input wire logic enableCmd,
    input wire logic biasGood,
    input wire logic otherFault,
    input wire logic faultClear,
    output logic outputEnable,
    output logic otWarning,
    output logic [1:0] faultLatched
);
    // A unit below one cycle would leave the restart timer without an end point
    if (RetryUnit < 1) begin : gBadUnit
        $error("RetryUnit must be at least one cycle");
    end
    logic [7:0] otReaction_reg;
    logic [7:0] vinReaction_reg;
    logic [15:0] otFaultLimit_reg;
    logic [15:0] otWarnLimit_reg;
    logic [15:0] vinOvLimit_reg;
    logic [1:0] faultSticky_reg;
    logic otWarn_reg;
    tvf_state_t state_reg [2];
    logic outOn_reg [2];
    logic [2:0] tries_reg [2];
    logic [2:0] steps_reg [2];
    logic [31:0] tick_reg [2];
    logic [1:0] faultNow;
    logic [7:0] reaction [2];
    logic stopAll;

    // Mantissa sits in bits 10:0; the exponent bits above it are fixed by the host
    function automatic logic signed [16:0] linMant(logic [15:0] word);
        return {{6{word[10]}}, word[10:0]};
    endfunction

    function automatic logic cmdHit(logic write, logic [7:0] code, logic [7:0] want);
        return write && code == want;
    endfunction

    // Settings stored as written; format is host's duty
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            otReaction_reg <= ReactionReset;
        end else if (cmdHit(link.cmdWrite, link.cmdCode, CmdOtFaultReaction)) begin
            otReaction_reg <= link.cmdData[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            vinReaction_reg <= ReactionReset;
        end else if (cmdHit(link.cmdWrite, link.cmdCode, CmdVinOvReaction)) begin
            vinReaction_reg <= link.cmdData[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            otFaultLimit_reg <= OtFaultLimitReset;
        end else if (cmdHit(link.cmdWrite, link.cmdCode, CmdOtFaultLimit)) begin
            otFaultLimit_reg <= link.cmdData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            otWarnLimit_reg <= OtWarnReset;
        end else if (cmdHit(link.cmdWrite, link.cmdCode, CmdOtWarnThreshold)) begin
            otWarnLimit_reg <= link.cmdData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            vinOvLimit_reg <= VinOvReset;
        end else if (cmdHit(link.cmdWrite, link.cmdCode, CmdVinOvThreshold)) begin
            vinOvLimit_reg <= link.cmdData;
        end
    end

    // Limits compared as signed linear mantissas with fixed exponents
    assign faultNow[0] = $signed({tempC[15], tempC}) > linMant(otFaultLimit_reg);
    assign faultNow[1] = $signed({1'b0, vinMilli8}) > linMant(vinOvLimit_reg);
    assign reaction[0] = otReaction_reg;
    assign reaction[1] = vinReaction_reg;
    assign stopAll = !enableCmd || !biasGood || otherFault;

    // Set wins over clear so a fault in the clearing cycle is kept
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            faultSticky_reg <= 2'h0;
        end else begin
            faultSticky_reg <= faultNow | (faultClear ? 2'h0 : faultSticky_reg);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            otWarn_reg <= 1'b0;
        end else begin
            otWarn_reg <= ($signed({tempC[15], tempC}) > linMant(otWarnLimit_reg))
                | (faultClear ? 1'b0 : otWarn_reg);
        end
    end

    for (genvar f = 0; f < 2; f++) begin : gFault
        logic [1:0] resp;
        logic [2:0] retries;
        logic [2:0] delay;
        logic trip;
        logic unitDone;
        logic delayDone;
        logic forceOff;
        logic restartNow;
        logic giveUp;
        logic releaseNow;
        assign resp = reaction[f][RespMsb:RespLsb];
        assign retries = reaction[f][RetryMsb:RetryLsb];
        assign delay = reaction[f][DelayMsb:DelayLsb];
        // Reserved codes 01 and 11 take the shutdown path
        assign trip = faultNow[f] && resp != RespIgnore;
        assign unitDone = tick_reg[f] == 32'(RetryUnit - 1);
        // Delay 0 is served as one unit so a retry never fires in the tripping cycle
        assign delayDone = steps_reg[f] + 3'h1 >= delay;
        assign forceOff = stopAll && retries == RetryForever;
        assign restartNow = unitDone && delayDone && !forceOff;
        assign giveUp = retries != RetryForever && tries_reg[f] >= retries;
        assign releaseNow = faultClear && !faultNow[f];

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                state_reg[f] <= TvfRun;
            end else begin
                unique case (state_reg[f])
                    TvfRun: begin
                        if (trip && retries == RetryNone) begin
                            state_reg[f] <= TvfLatched;
                        end else if (trip) begin
                            state_reg[f] <= TvfWait;
                        end
                    end
                    TvfWait: begin
                        if (giveUp || forceOff) begin
                            state_reg[f] <= TvfLatched;
                        end else if (restartNow) begin
                            state_reg[f] <= TvfRun;
                        end
                    end
                    TvfLatched: begin
                        if (releaseNow) begin
                            state_reg[f] <= TvfRun;
                        end
                    end
                    default: state_reg[f] <= TvfLatched;
                endcase
            end
        end

        // Output follows the state decision one edge after the event
        always_ff @(posedge clk_sys) begin
            if (reset) begin
                outOn_reg[f] <= 1'b1;
            end else begin
                unique case (state_reg[f])
                    TvfRun: outOn_reg[f] <= !trip;
                    TvfWait: outOn_reg[f] <= restartNow && !giveUp;
                    TvfLatched: outOn_reg[f] <= releaseNow;
                    default: outOn_reg[f] <= 1'b0;
                endcase
            end
        end

        // Timer only runs while waiting; any other state rearms it
        always_ff @(posedge clk_sys) begin
            if (reset || state_reg[f] != TvfWait) begin
                tick_reg[f] <= 32'h0;
                steps_reg[f] <= 3'h0;
            end else if (!forceOff) begin
                if (unitDone) begin
                    tick_reg[f] <= 32'h0;
                    steps_reg[f] <= delayDone ? 3'h0 : steps_reg[f] + 3'h1;
                end else begin
                    tick_reg[f] <= tick_reg[f] + 32'h1;
                end
            end
        end

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                tries_reg[f] <= 3'h0;
            end else if (state_reg[f] == TvfWait && restartNow) begin
                tries_reg[f] <= tries_reg[f] + 3'h1;
            end else if (state_reg[f] == TvfLatched && releaseNow) begin
                tries_reg[f] <= 3'h0;
            end
        end
    end

    assign outputEnable = outOn_reg[0] && outOn_reg[1] && !stopAll;
    assign otWarning = otWarn_reg;
    assign faultLatched = faultSticky_reg;
    assign link.faultStatus = {5'h0, otWarn_reg, faultSticky_reg};
endmodule // tvf_fault_device

// ---- tvf_host_ctrl.sv ----
// Host controller: software register port turned into device command writes.
// Assumes software writes data words before the command code, which fires the write.
`timescale 1ns/1ps
module tvf_host_ctrl
    import tvf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    tvf_link_if.host link,
    input wire logic [2:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata
);
    logic [7:0] dataLo_reg;
    logic [7:0] dataHi_reg;
    logic cmdWrite_reg;
    logic [7:0] cmdCode_reg;
    logic [15:0] cmdData_reg;
    logic [15:0] rdata_reg;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dataLo_reg <= 8'h0;
            dataHi_reg <= 8'h0;
        end else if (regWrite && regAddr == CtlAddrDataLo) begin
            dataLo_reg <= regWdata[7:0];
        end else if (regWrite && regAddr == CtlAddrDataHi) begin
            dataHi_reg <= regWdata[7:0];
        end
    end

    // Limit formats (exponent 0 or -3) are software's duty; passed as raw words
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cmdWrite_reg <= 1'b0;
            cmdCode_reg <= 8'h0;
            cmdData_reg <= 16'h0;
        end else begin
            cmdWrite_reg <= regWrite && regAddr == CtlAddrCmd;
            if (regWrite && regAddr == CtlAddrCmd) begin
                cmdCode_reg <= regWdata[7:0];
                cmdData_reg <= {dataHi_reg, dataLo_reg};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_reg <= 16'h0;
        end else if (regRead) begin
            unique case (regAddr)
                CtlAddrCmd: rdata_reg <= {8'h0, cmdCode_reg};
                CtlAddrDataLo: rdata_reg <= {8'h0, dataLo_reg};
                CtlAddrDataHi: rdata_reg <= {8'h0, dataHi_reg};
                CtlAddrStatus: rdata_reg <= {8'h0, link.faultStatus};
                default: rdata_reg <= 16'h0;
            endcase
        end else begin
            rdata_reg <= 16'h0;
        end
    end

    assign link.cmdWrite = cmdWrite_reg;
    assign link.cmdCode = cmdCode_reg;
    assign link.cmdData = cmdData_reg;
    assign regRdata = rdata_reg;
endmodule // tvf_host_ctrl

// ---- tvf_link_properties.sv ----
// Checker for the command link between the host controller and the fault device.
// Sees only link signals; the testbench instantiates it beside the interface.
`timescale 1ns/1ps
module tvf_link_properties (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cmdWrite,
    input wire logic [7:0] cmdCode,
    input wire logic [15:0] cmdData,
    input wire logic [7:0] faultStatus
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    a_strobe_single: assert property (cmdWrite |=> !cmdWrite)
        else $error("command strobe too long");
    a_code_known: assert property (cmdWrite |-> cmdCode inside {8'h4f, 8'h50, 8'h51, 8'h55, 8'h56})
        else $error("unknown command code");
    a_fault_exp: assert property (cmdWrite && cmdCode == 8'h4f |-> cmdData[15:11] == 5'h00)
        else $error("fault limit exponent");
    a_warn_exp: assert property (cmdWrite && cmdCode == 8'h51 |-> cmdData[15:11] == 5'h00)
        else $error("warning limit exponent");
    a_vin_exp: assert property (cmdWrite && cmdCode == 8'h55 |-> cmdData[15:11] == 5'h1d)
        else $error("input limit exponent");
    a_status_top_zero: assert property (faultStatus[7:3] == 5'h00)
        else $error("status spare bits set");
    a_reset_quiet: assert property (disable iff (1'b0) reset |=> !cmdWrite)
        else $error("strobe after reset");
    a_reset_status: assert property (disable iff (1'b0) reset |=> faultStatus == 8'h00)
        else $error("status not cleared by reset");
    c_ot_reaction: cover property (cmdWrite && cmdCode == 8'h50);
    c_vin_reaction: cover property (cmdWrite && cmdCode == 8'h56);
    c_vin_sticky: cover property ($rose(faultStatus[1]));
endmodule // tvf_link_properties

// ---- tb_temp_vin_fault_response.sv ----
// Self-checking bench: host controller and fault device joined by the link interface.
// Restart unit shortened to 4 cycles; inputs driven by non-blocking assignment at posedge.
`timescale 1ns/1ps
module tb_temp_vin_fault_response;
    import tvf_pkg::*;
    localparam int U = 4;
    logic clk_sys, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, outputEnable, otWarning;
    logic enableCmd = 1'b1, biasGood = 1'b1, otherFault = 1'b0, faultClear = 1'b0, w;
    logic [2:0] regAddr = 3'h0;
    logic [15:0] regWdata = 16'h0000, regRdata, rdv, tempC = 16'd25, vinMilli8 = 16'd0;
    logic [1:0] faultLatched;
    int n_fail = 0, comparisons = 0, cnt;
    tvf_link_if link();
    tvf_host_ctrl tvf_host_ctrl_inst (.clk_sys(clk_sys), .reset(reset), .link(link),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata));
    tvf_fault_device #(.RetryUnit(U)) tvf_fault_device_inst (.clk_sys(clk_sys), .reset(reset),
        .link(link), .tempC(tempC), .vinMilli8(vinMilli8), .enableCmd(enableCmd),
        .biasGood(biasGood), .otherFault(otherFault), .faultClear(faultClear),
        .outputEnable(outputEnable), .otWarning(otWarning), .faultLatched(faultLatched));
    tvf_link_properties tvf_link_properties_inst (.clk_sys(clk_sys), .reset(reset),
        .cmdWrite(link.cmdWrite), .cmdCode(link.cmdCode), .cmdData(link.cmdData),
        .faultStatus(link.faultStatus));
    task automatic test_done();
        if (n_fail == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    task automatic rd(logic [2:0] a);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 rdv = regRdata;
    endtask
    // Data bytes first: the code write is what fires the command
    task automatic cmd(logic [7:0] c, logic [15:0] d);
        wr(CtlAddrDataLo, {8'h00, d[7:0]});
        wr(CtlAddrDataHi, {8'h00, d[15:8]});
        wr(CtlAddrCmd, {8'h00, c});
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic wl(logic v);
        for (int i = 0; i < 300 && outputEnable !== v; i++) @(negedge clk_sys);
        if (outputEnable !== v) begin
            chk("outputEnable wait", {15'h0, v}, {15'h0, outputEnable});
            test_done();
        end
    endtask
    task automatic flt(logic x, logic on);
        @(posedge clk_sys);
        if (x) vinMilli8 <= on ? 16'd900 : 16'd400;
        else tempC <= on ? 16'd130 : 16'd25;
    endtask
    task automatic clr();
        @(posedge clk_sys);
        faultClear <= 1'b1;
        @(posedge clk_sys);
        faultClear <= 1'b0;
        wl(1'b1);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        cmd(CmdVinOvThreshold, {5'h1d, 11'd800});
        vinMilli8 <= 16'd400;
        cmd(CmdOtFaultLimit, 16'd125);
        chk("otWarning idle", 16'h0, {15'h0, otWarning});
        cmd(CmdOtWarnThreshold, 16'd100);
        tempC <= 16'd110;
        repeat (3) @(posedge clk_sys);
        #1 chk("otWarning", 16'h3, {14'h0, outputEnable, otWarning});
        flt(1'b0, 1'b0);
        clr();
        @(posedge clk_sys);
        biasGood <= 1'b0;
        #1 chk("biasOff", 16'h0, {15'h0, outputEnable});
        @(posedge clk_sys);
        biasGood <= 1'b1;
        otherFault <= 1'b1;
        #1 chk("otherOff", 16'h0, {15'h0, outputEnable});
        @(posedge clk_sys);
        otherFault <= 1'b0;
        wr(3'h6, 16'hffff);
        rd(3'h5);
        chk("unmapped", 16'h0, rdv);
        // Every response code, no retries: only 00 keeps the output up
        for (int r = 0; r < 4; r++) begin
            cmd(CmdOtFaultReaction, {8'h00, 2'(r), 6'h00});
            flt(1'b0, 1'b1);
            repeat (20) @(posedge clk_sys);
            #1 chk("outputEnable", {15'h0, r == 0}, {15'h0, outputEnable});
            chk("faultLatched", 16'h1, {15'h0, faultLatched[0]});
            rd(CtlAddrStatus);
            chk("otSticky", 16'h1, {15'h0, rdv[0]});
            flt(1'b0, 1'b0);
            clr();
        end
        // Retry counts 1 to 7 with delay equal to count, faults alternating
        for (int n = 1; n < 8; n++) begin
            w = n[0];
            cmd(w ? CmdVinOvReaction : CmdOtFaultReaction, {8'h00, 2'b10, 3'(n), 3'(n)});
            flt(w, 1'b1);
            for (int a = 0; a < (n == 7 ? 9 : n); a++) begin
                wl(1'b0);
                for (cnt = 0; outputEnable === 1'b0 && cnt < 100; cnt++) @(negedge clk_sys);
                chk("offCycles", 16'(n * U), 16'(cnt));
            end
            wl(1'b0);
            if (n == 7) begin
                @(posedge clk_sys);
                enableCmd <= 1'b0;
                @(posedge clk_sys);
                enableCmd <= 1'b1;
            end
            repeat (60) @(negedge clk_sys);
            chk("latchedOff", 16'h3, {14'h0, faultLatched[w], !outputEnable});
            flt(w, 1'b0);
            clr();
        end
        test_done();
    end
endmodule // tb_temp_vin_fault_response
